// [sim/sse_exec_checker.sv]
// Assertion checker on the execution block ports
`timescale 1ns/10ps
module sse_exec_checker
  import sse_pkg::*;
#(
  parameter int PC_BITS = 11,
  parameter int ROM_BITS = 14
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic issue,
  input sse_op_t op,
  input wire logic [7:0] mem_rdata,
  input wire logic [2:0] bit_sel,
  input wire logic [PC_BITS-1:0] pc,
  input wire logic [7:0] rom_lookup_pointer,
  input wire logic [ROM_BITS-1:0] rom_rdata,
  input wire logic busy,
  input wire logic done,
  input wire logic skip_taken,
  input wire logic [7:0] acc,
  input wire logic [7:0] rom_lookup_upper_byte,
  input wire logic mem_we,
  input wire logic [7:0] mem_wdata,
  input wire logic rom_re,
  input wire logic [PC_BITS-1:0] rom_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire go = issue && !busy;
  wire [7:0] m = mem_rdata;
  AST_INC_SKIP: assert property (go && op == SSE_OP_INC_SKIP |=>
    acc == $past(m) + 8'h01 && !mem_we) else $error("bad increment skip");
  AST_SKIP: assert property (skip_taken |-> busy && !done ##1 done && !busy)
    else $error("bad skip");
  AST_BIT: assert property (go && op inside {SSE_OP_BSET, SSE_OP_BCLR} &&
    m[bit_sel] == (op == SSE_OP_BSET) |=> skip_taken) else $error("bad bit");
  AST_SUB_MEM: assert property (go && op == SSE_OP_SUB_MEM |=>
    mem_we && mem_wdata == $past(acc) + ~$past(m) + 8'h01) else $error("bad subtract to memory");
  AST_SWAP: assert property (go && op inside {SSE_OP_SWAP, SSE_OP_SWAP_ACC} |=>
    mem_we == ($past(op) == SSE_OP_SWAP) &&
    (mem_we ? mem_wdata : acc) == ($past(m) << 4 | $past(m) >> 4)) else $error("bad swap");
  AST_ZERO: assert property (go && op inside {SSE_OP_CPSZ, SSE_OP_TSTZ} |=>
    !mem_we && skip_taken == ($past(m) == 8'h00)) else $error("bad zero");
  AST_XOR: assert property (go && op inside {SSE_OP_XORA, SSE_OP_XOR_MEM} |=>
    (mem_we ? mem_wdata : acc) == ($past(acc) ^ $past(m))) else $error("bad xor");
  AST_TABLE: assert property (go && op inside {SSE_OP_TRDC, SSE_OP_TRDL} |=>
    rom_re && rom_addr[7:0] == $past(rom_lookup_pointer) && ($past(op) == SSE_OP_TRDL ?
    &rom_addr[PC_BITS-1:8] : rom_addr >> 8 == $past(pc) >> 8) ##1 mem_we &&
    mem_wdata == 8'($past(rom_rdata)) && rom_lookup_upper_byte == 8'($past(rom_rdata) >> 8))
    else $error("bad table");
endmodule : sse_exec_checker

// [sim/sse_exec_tb.sv]
// Self-checking bench for the execution block
`timescale 1ns/10ps
module sse_exec_tb;
  import sse_pkg::*;
  logic clk = 1'h0, rst_b = 1'h0, issue = 1'h0, sk;
  sse_op_t op = SSE_OP_NONE;
  logic [7:0] mem_rdata = 8'h00, imm = 8'h00, rom_lookup_pointer = 8'h34;
  logic [2:0] bit_sel = 3'h0;
  logic [10:0] pc = 11'h2ab, rom_addr;
  logic [13:0] rom_rdata = 14'h2a5c;
  logic busy, done, skip_taken, zero_flag, carry_flag, mem_we, rom_re;
  logic [7:0] acc, rom_lookup_upper_byte, mem_wdata;
  int n_mismatch = 0, checked = 0;
  sse_exec dut (.*);
  initial forever #12.5 clk = ~clk;
  task end_sim;
    $display("checked %0d mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim
  task chk(string n, logic [13:0] s, e);
    checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  // Flags f: skip expected, memory write expected
  task ex(sse_op_t o, logic [7:0] m, logic [1:0] f, logic [7:0] e, logic [2:0] b = 3'h0);
    @(posedge clk);
    issue <= 1'h1;
    op <= o;
    mem_rdata <= m;
    imm <= m;
    bit_sel <= b;
    @(posedge clk);
    issue <= 1'h0;
    @(negedge clk);
    sk = skip_taken;
    for (int k = 0; k < 3 && done !== 1'h1; k++) @(negedge clk);
    if (done !== 1'h1) begin
      n_mismatch++;
      end_sim;
    end
    chk("skip", sk, f[1]);
    chk("we", mem_we, f[0]);
    chk("res", f[0] ? mem_wdata : acc, e);
  endtask : ex
  task t_skip;
    ex(SSE_OP_INC_SKIP, 8'hff, 2'h2, 8'h00);
    ex(SSE_OP_INC_SKIP, 8'h41, 2'h0, 8'h42);
    ex(SSE_OP_BSET, 8'h80, 2'h2, 8'h42, 3'h7);
    ex(SSE_OP_BSET, 8'hfe, 2'h0, 8'h42);
    ex(SSE_OP_BCLR, 8'h7f, 2'h2, 8'h42, 3'h7);
    ex(SSE_OP_BCLR, 8'h08, 2'h0, 8'h42, 3'h3);
    ex(SSE_OP_CPSZ, 8'h00, 2'h2, 8'h00);
    ex(SSE_OP_TSTZ, 8'h07, 2'h0, 8'h00);
    ex(SSE_OP_TSTZ, 8'h00, 2'h2, 8'h00);
  endtask : t_skip
  task t_alu;
    ex(SSE_OP_XORI, 8'h07, 2'h0, 8'h07);
    chk("zero", zero_flag, 1'h0);
    ex(SSE_OP_XORA, 8'h07, 2'h0, 8'h00);
    chk("zero", zero_flag, 1'h1);
    ex(SSE_OP_SUBI, 8'h10, 2'h0, 8'hf0);
    chk("carry", carry_flag, 1'h0);
    ex(SSE_OP_SUB_MEM, 8'h01, 2'h1, 8'hef);
    chk("carry", carry_flag, 1'h1);
    ex(SSE_OP_XOR_MEM, 8'h0f, 2'h1, 8'hff);
    ex(SSE_OP_SWAP, 8'h3c, 2'h1, 8'hc3);
    ex(SSE_OP_SWAP_ACC, 8'ha5, 2'h0, 8'h5a);
    ex(SSE_OP_SUBA, 8'h5b, 2'h0, 8'hff);
    chk("carry", carry_flag, 1'h0);
  endtask : t_alu
  task t_table;
    ex(SSE_OP_TRDC, 8'h00, 2'h1, 8'h5c);
    chk("upper", rom_lookup_upper_byte, 8'h2a);
    chk("addr", rom_addr, 11'h234);
    @(posedge clk);
    rom_rdata <= 14'h3fc1;
    ex(SSE_OP_TRDL, 8'h00, 2'h1, 8'hc1);
    chk("upper", rom_lookup_upper_byte, 8'h3f);
    chk("addr", rom_addr, 11'h734);
  endtask : t_table
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'h1;
    t_skip;
    t_alu;
    t_table;
    end_sim;
  end
endmodule : sse_exec_tb
bind sse_exec sse_exec_checker #(.PC_BITS(PC_BITS), .ROM_BITS(ROM_BITS)) u_chk (.*);

// [src/sse_alu.sv]
// Combinational result, destination and skip decision per operation
`timescale 1ns/10ps
module sse_alu
  import sse_pkg::*;
(
  sse_alu_if.alu a
);
  logic [8:0] sum;
  always_comb begin
    sum = 9'h000;
    a.result = 8'h00;
    a.to_acc = 1'b0;
    a.to_mem = 1'b0;
    a.skip = 1'b0;
    a.zero_upd = 1'b0;
    a.carry_upd = 1'b0;
    unique case (a.op)
      SSE_OP_INC_SKIP: begin
        a.result = a.mem + 8'h01;
        a.to_acc = 1'b1;
        a.skip = (a.result == 8'h00);
      end
      SSE_OP_BSET: a.skip = a.mem[a.bit_sel];
      SSE_OP_BCLR: a.skip = ~a.mem[a.bit_sel];
      SSE_OP_SUBA, SSE_OP_SUBI, SSE_OP_SUB_MEM: begin
        if (a.op == SSE_OP_SUBI) begin
          sum = {1'b0, a.acc} + {1'b0, ~a.imm} + 9'h001;
        end else begin
          sum = {1'b0, a.acc} + {1'b0, ~a.mem} + 9'h001;
        end
        a.result = sum[7:0];
        a.to_acc = (a.op != SSE_OP_SUB_MEM);
        a.to_mem = (a.op == SSE_OP_SUB_MEM);
        a.zero_upd = 1'b1;
        a.carry_upd = 1'b1;
      end
      SSE_OP_SWAP: begin
        a.result = {a.mem[3:0], a.mem[7:4]};
        a.to_mem = 1'b1;
      end
      SSE_OP_SWAP_ACC: begin
        a.result = {a.mem[3:0], a.mem[7:4]};
        a.to_acc = 1'b1;
      end
      SSE_OP_CPSZ: begin
        a.result = a.mem;
        a.to_acc = 1'b1;
        a.skip = (a.mem == 8'h00);
      end
      SSE_OP_TSTZ: a.skip = (a.mem == 8'h00);
      SSE_OP_XORA: begin
        a.result = a.acc ^ a.mem;
        a.to_acc = 1'b1;
        a.zero_upd = 1'b1;
      end
      SSE_OP_XOR_MEM: begin
        a.result = a.acc ^ a.mem;
        a.to_mem = 1'b1;
        a.zero_upd = 1'b1;
      end
      SSE_OP_XORI: begin
        a.result = a.acc ^ a.imm;
        a.to_acc = 1'b1;
        a.zero_upd = 1'b1;
      end
      default: a.result = 8'h00;
    endcase
  end
  assign a.carry = sum[8];
endmodule : sse_alu

// [src/sse_alu_if.sv]
// Carrier between the sequencer and the combinational ALU
`timescale 1ns/10ps
interface sse_alu_if;
  import sse_pkg::*;
  sse_op_t op;
  logic [7:0] acc;
  logic [7:0] mem;
  logic [7:0] imm;
  logic [2:0] bit_sel;
  logic [7:0] result;
  logic to_acc;
  logic to_mem;
  logic skip;
  logic zero_upd;
  logic carry_upd;
  logic carry;
  modport seq (output op, acc, mem, imm, bit_sel,
               input result, to_acc, to_mem, skip, zero_upd, carry_upd, carry);
  modport alu (input op, acc, mem, imm, bit_sel,
               output result, to_acc, to_mem, skip, zero_upd, carry_upd, carry);
endinterface : sse_alu_if

// [src/sse_exec.sv]
// Execution sequencer: accumulator, flags, table read, skip timing
`timescale 1ns/10ps
`include "sse_regs.svh"
// Operation
// - Increment memory byte into accumulator, memory unchanged, skip when sum zero.
// - Met skip discards prefetched instruction with dummy cycle: two cycles, else one.
// - Bit-set test skips next instruction when selected memory bit is one.
// - Subtract into accumulator is acc plus inverted operand plus one.
// - Subtract into memory writes acc plus inverted memory plus one back.
// - Nibble swap exchanges memory byte halves and stores back.
// - Nibble exchange puts swapped memory byte into accumulator, memory unchanged.
// - Copy memory to accumulator, skip when copied value is zero.
// - Bit-clear test skips next instruction when selected memory bit is zero.
// - Current-page table read: low byte to memory, high byte to upper register.
// - Last-page table read: low byte to memory, high byte to upper register.
// - Xor accumulator with memory into accumulator, update zero flag.
// - Xor into memory writes result back, update zero flag.
// - Xor immediate into accumulator, update zero flag.
module sse_exec
  import sse_pkg::*;
#(
  parameter int PC_BITS = 11,
  parameter int ROM_BITS = 14
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic issue,
  input sse_op_t op,
  input wire logic [7:0] mem_rdata,
  input wire logic [7:0] imm,
  input wire logic [2:0] bit_sel,
  input wire logic [PC_BITS-1:0] pc,
  input wire logic [7:0] rom_lookup_pointer,
  input wire logic [ROM_BITS-1:0] rom_rdata,
  output logic busy,
  output logic done,
  output logic skip_taken,
  output logic [7:0] acc,
  output logic zero_flag,
  output logic carry_flag,
  output logic [7:0] rom_lookup_upper_byte,
  output logic mem_we,
  output logic [7:0] mem_wdata,
  output logic rom_re,
  output logic [PC_BITS-1:0] rom_addr
);
  localparam int PB = `SSE_PAGE_BITS;
  sse_alu_if alu_c ();
  sse_state_t state;
  logic accept;
  logic is_table;

  assign accept = issue && (state == SSE_ST_IDLE);
  assign is_table = (op == SSE_OP_TRDC) || (op == SSE_OP_TRDL);
  assign alu_c.op = op;
  assign alu_c.acc = acc;
  assign alu_c.mem = mem_rdata;
  assign alu_c.imm = imm;
  assign alu_c.bit_sel = bit_sel;

  sse_alu u_alu (
    .a(alu_c)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= SSE_ST_IDLE;
    end else begin
      unique case (state)
        SSE_ST_IDLE: begin
          if (accept && is_table) begin
            state <= SSE_ST_TABLE;
          end else if (accept && alu_c.skip) begin
            state <= SSE_ST_DUMMY;
          end
        end
        SSE_ST_TABLE: state <= SSE_ST_IDLE;
        SSE_ST_DUMMY: state <= SSE_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
      done <= 1'b0;
      skip_taken <= 1'b0;
    end else begin
      busy <= accept && (is_table || alu_c.skip);
      done <= (accept && !is_table && !alu_c.skip) || (state != SSE_ST_IDLE);
      skip_taken <= accept && !is_table && alu_c.skip;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator and flags
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acc <= `SSE_ACC_RESET;
    end else if (accept && alu_c.to_acc) begin
      acc <= alu_c.result;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      zero_flag <= `SSE_ZERO_RESET;
      carry_flag <= `SSE_CARRY_RESET;
    end else if (accept) begin
      if (alu_c.zero_upd) begin
        zero_flag <= (alu_c.result == 8'h00);
      end
      if (alu_c.carry_upd) begin
        carry_flag <= alu_c.carry;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory write and table read
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rom_re <= 1'b0;
      rom_addr <= '0;
    end else begin
      rom_re <= accept && is_table;
      if (accept && op == SSE_OP_TRDC) begin
        rom_addr <= {pc[PC_BITS-1:PB], rom_lookup_pointer};
      end else if (accept && op == SSE_OP_TRDL) begin
        rom_addr <= {{(PC_BITS-PB){1'b1}}, rom_lookup_pointer};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_we <= 1'b0;
      mem_wdata <= 8'h00;
      rom_lookup_upper_byte <= `SSE_UPPER_RESET;
    end else begin
      mem_we <= 1'b0;
      if (accept && alu_c.to_mem) begin
        mem_we <= 1'b1;
        mem_wdata <= alu_c.result;
      end else if (state == SSE_ST_TABLE) begin
        mem_we <= 1'b1;
        mem_wdata <= rom_rdata[7:0];
        rom_lookup_upper_byte <= 8'(rom_rdata[ROM_BITS-1:8]);
      end
    end
  end
endmodule : sse_exec

// [src/sse_pkg.sv]
// Types for the skip/sub/swap/xor/table execution block
package sse_pkg;
  typedef enum logic [3:0] {
    SSE_OP_NONE   = 4'h0,
    SSE_OP_INC_SKIP = 4'h1,
    SSE_OP_BSET   = 4'h2,
    SSE_OP_BCLR   = 4'h3,
    SSE_OP_SUBA   = 4'h4,
    SSE_OP_SUBI   = 4'h5,
    SSE_OP_SUB_MEM = 4'h6,
    SSE_OP_SWAP   = 4'h7,
    SSE_OP_SWAP_ACC = 4'h8,
    SSE_OP_CPSZ   = 4'h9,
    SSE_OP_TSTZ   = 4'ha,
    SSE_OP_TRDC   = 4'hb,
    SSE_OP_TRDL   = 4'hc,
    SSE_OP_XORA   = 4'hd,
    SSE_OP_XOR_MEM = 4'he,
    SSE_OP_XORI   = 4'hf
  } sse_op_t;
  typedef enum logic [2:0] {
    SSE_ST_IDLE  = 3'b001,
    SSE_ST_TABLE = 3'b010,
    SSE_ST_DUMMY = 3'b100
  } sse_state_t;
endpackage : sse_pkg

// [src/sse_regs.svh]
// Constants for the skip/sub/swap/xor/table execution block
`ifndef SSE_REGS_SVH
`define SSE_REGS_SVH
`define SSE_ACC_RESET 8'h00
`define SSE_UPPER_RESET 8'h00
`define SSE_ZERO_RESET 1'b0
`define SSE_CARRY_RESET 1'b0
`define SSE_PAGE_BITS 8
`endif
